// File: core/hppc_pkg.sv
// Constants and register map for the halt and peripheral power control block
// Operation
// - Sleep instruction puts device in sleep mode; CPU stops, peripherals stay active.
// - In sleep the oscillator and system clock run; program counter holds.
// - In sleep the watchdog oscillator, watchdog and other peripherals keep running.
// - Interrupt, watchdog timeout, power-on, brown-out or external reset end sleep.
// - Power control register returns to reset value only on power-on reset.
// - Each disable bit gates its peripheral's clock or power.
// - Bit 4 disables brown-out detector; active only if option bit also enables.
// - Bit 2 set disables the ADC, cleared enables it.
// - Bit 1 set disables the comparator, cleared enables it.
package hppc_pkg;
   localparam int unsigned   ADDR_W          = 12;
   localparam int unsigned   DATA_W          = 8;
   localparam logic [11:0]   PWR_CTL0_ADDR   = 12'hF80;
   localparam logic [7:0]    PWR_CTL0_RESET  = 8'h80;
   localparam int unsigned   BIT_BOD_OFF     = 4;
   localparam int unsigned   BIT_ADC_OFF     = 2;
   localparam int unsigned   BIT_COMP_OFF    = 1;
   localparam int unsigned   SYNC_STAGES     = 3;

   // CPU run state
   typedef enum logic [1:0]
   {
      HPPC_RUN  = 2'b01,
      HPPC_HALT = 2'b10
   } hppc_state_type;
endpackage

// File: core/hppc_sync.sv
// Three-stage pin synchroniser with agreement filter
module hppc_sync
   import hppc_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic pin_in,
   output logic      level_q
);
   logic [SYNC_STAGES-1:0] stage_q;

   // Stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         stage_q <= '1; // Idle high, so no false wake after reset
         level_q <= 1'b1;
      end
      else
      begin
         stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
         if (stage_q[1] == stage_q[2])
            level_q <= stage_q[2];
      end
   end
endmodule

// File: core/hppc_top.sv
// Halt mode control and peripheral power control register
module hppc_top
   import hppc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic              por_pulse,
   input  wire logic              halt_exec,
   input  wire logic              irq_pending,
   input  wire logic              wdt_timeout,
   input  wire logic              bor_reset,
   input  wire logic              ext_reset_n_pin,
   input  wire logic              brownout_always_on_option,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic       [DATA_W-1:0] reg_rdata,
   output logic                    cpu_halted,
   output logic                    pc_hold,
   output logic                    cpu_clk_en,
   output logic                    sys_clk_en,
   output logic                    wdt_osc_en,
   output logic                    brownout_detector_off,
   output logic                    brownout_active,
   output logic                    adc_clk_en,
   output logic                    comp_clk_en
);
   hppc_state_type state_q;
   logic [DATA_W-1:0] pwr_ctl0_q;
   logic              ext_rst_n_lvl;
   logic              wake_event;
   logic              reg_hit;

   // Reset pin comes from outside; filter it before use
   hppc_sync u_ext_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pin_in   (ext_reset_n_pin),
      .level_q  (ext_rst_n_lvl)
   );

   // Any wake source ends halt; a low synced pin counts as the reset pin asserted
   assign wake_event = irq_pending | wdt_timeout | por_pulse | bor_reset
                       | ~ext_rst_n_lvl;
   assign reg_hit    = (reg_addr == PWR_CTL0_ADDR);

   // Halt state machine
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         state_q <= HPPC_RUN;
      else
      begin
         case (state_q)
            HPPC_RUN:
               if (halt_exec && !wake_event)
                  state_q <= HPPC_HALT;
            HPPC_HALT:
               if (wake_event)
                  state_q <= HPPC_RUN;
            default:
               state_q <= HPPC_RUN;
         endcase
      end
   end

   // Core clock and PC gated in halt; system and watchdog clocks run on
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         cpu_halted <= 1'b0;
         pc_hold    <= 1'b0;
         cpu_clk_en <= 1'b1;
         sys_clk_en <= 1'b1;
         wdt_osc_en <= 1'b1;
      end
      else
      begin
         cpu_halted <= (state_q == HPPC_HALT);
         pc_hold    <= (state_q == HPPC_HALT);
         cpu_clk_en <= (state_q != HPPC_HALT);
         sys_clk_en <= 1'b1;
         wdt_osc_en <= 1'b1;
      end
   end

   // Register only knows power-on reset; system reset leaves it alone
   always_ff @(posedge core_clk)
   begin
      if (por_pulse)
         pwr_ctl0_q <= PWR_CTL0_RESET;
      else if (reg_wr && reg_hit)
         pwr_ctl0_q <= reg_wdata;
   end

   // Read data one cycle after strobe; unmapped reads return zero
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         reg_rdata <= '0;
      else if (reg_rd && reg_hit)
         reg_rdata <= pwr_ctl0_q;
      else
         reg_rdata <= '0;
   end

   // Peripheral gates; halt does not touch them
   always_ff @(posedge core_clk)
   begin
      if (por_pulse)
      begin
         brownout_detector_off <= PWR_CTL0_RESET[BIT_BOD_OFF];
         brownout_active       <= 1'b0;
         adc_clk_en            <= 1'b0;
         comp_clk_en           <= 1'b0;
      end
      else
      begin
         brownout_detector_off <= pwr_ctl0_q[BIT_BOD_OFF];
         brownout_active       <= ~pwr_ctl0_q[BIT_BOD_OFF]
                                  & brownout_always_on_option;
         adc_clk_en            <= ~pwr_ctl0_q[BIT_ADC_OFF];
         comp_clk_en           <= ~pwr_ctl0_q[BIT_COMP_OFF];
      end
   end

   // Reserved bits are stored as written; software keeps them at legal values
   // Gate checks skip cycles where power-on reset overrides the register

   property p_halt_entry;
      @(posedge core_clk) disable iff (!resetn)
      (state_q == HPPC_RUN && halt_exec && !wake_event) |=> ##1 cpu_halted && pc_hold;
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");

   property p_clk_gate;
      @(posedge core_clk) disable iff (!resetn)
      cpu_halted |-> !cpu_clk_en && sys_clk_en;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("clock gating wrong in halt");

   property p_wdt_run;
      @(posedge core_clk) disable iff (!resetn) ##1 wdt_osc_en;
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("watchdog osc stopped");

   property p_wake;
      @(posedge core_clk) disable iff (!resetn)
      (state_q == HPPC_HALT && (irq_pending || wdt_timeout || bor_reset)) |=> ##1 !cpu_halted;
   endproperty
   a_wake: assert property (p_wake) else $error("halt not exited");

   property p_por;
      @(posedge core_clk) por_pulse |=> pwr_ctl0_q == PWR_CTL0_RESET;
   endproperty
   a_por: assert property (p_por) else $error("por value wrong");

   property p_sysrst_keep;
      @(posedge core_clk) (!resetn && !por_pulse && !reg_wr) |=> $stable(pwr_ctl0_q);
   endproperty
   a_sysrst_keep: assert property (p_sysrst_keep) else $error("reg lost");

   property p_bod;
      @(posedge core_clk)
      !por_pulse |=> brownout_active == (!$past(pwr_ctl0_q[BIT_BOD_OFF])
                                         && $past(brownout_always_on_option));
   endproperty
   a_bod: assert property (p_bod) else $error("brownout gate wrong");

   property p_adc;
      @(posedge core_clk) !por_pulse |=> adc_clk_en == !$past(pwr_ctl0_q[BIT_ADC_OFF]);
   endproperty
   a_adc: assert property (p_adc) else $error("adc gate wrong");

   property p_comp;
      @(posedge core_clk)
      !por_pulse |=> comp_clk_en == !$past(pwr_ctl0_q[BIT_COMP_OFF]);
   endproperty
   a_comp: assert property (p_comp) else $error("comparator gate wrong");

   property p_readback;
      @(posedge core_clk) disable iff (!resetn || por_pulse)
      (reg_wr && reg_hit) ##1 (reg_rd && reg_hit && !reg_wr) |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");

   property p_ext_wake;
      @(posedge core_clk) disable iff (!resetn)
      (state_q == HPPC_HALT && (por_pulse || !ext_rst_n_lvl)) |=> ##1 !cpu_halted;
   endproperty
   a_ext_wake: assert property (p_ext_wake) else $error("reset wake missed");

   property p_run_clk;
      @(posedge core_clk) disable iff (!resetn)
      !cpu_halted |-> cpu_clk_en && !pc_hold;
   endproperty
   a_run_clk: assert property (p_run_clk) else $error("core clock gated while running");

   property p_rd_idle;
      @(posedge core_clk)
      !(reg_rd && reg_hit) |=> reg_rdata == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

   property p_reg_keep;
      @(posedge core_clk)
      (!por_pulse && !(reg_wr && reg_hit)) |=> $stable(pwr_ctl0_q);
   endproperty
   a_reg_keep: assert property (p_reg_keep) else $error("register changed unasked");

   property p_bod_flag;
      @(posedge core_clk)
      !por_pulse |=> brownout_detector_off == $past(pwr_ctl0_q[BIT_BOD_OFF]);
   endproperty
   a_bod_flag: assert property (p_bod_flag) else $error("brownout off flag wrong");

   // Main scenarios worth seeing at least once
   c_halt: cover property (@(posedge core_clk) cpu_halted ##1 !cpu_halted);
   c_wr: cover property (@(posedge core_clk) reg_wr && reg_hit);
   c_adc_off: cover property (@(posedge core_clk) !adc_clk_en && resetn);
   c_ext_wake: cover property (@(posedge core_clk) state_q == HPPC_HALT && !ext_rst_n_lvl);
   c_b2b: cover property (@(posedge core_clk) (reg_wr && reg_hit) ##1 (reg_rd && reg_hit));
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the halt and peripheral power control block
module tb_top
   import hppc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk = 0, resetn = 0, por_pulse = 1, halt_exec = 0;
   logic               irq_pending = 0, wdt_timeout = 0, bor_reset = 0;
   logic               ext_reset_n_pin = 1, brownout_always_on_option = 1;
   logic [ADDR_W-1:0]  reg_addr = '0;
   logic [DATA_W-1:0]  reg_wdata = '0, reg_rdata;
   logic               reg_wr = 0, reg_rd = 0;
   logic               cpu_halted, pc_hold, cpu_clk_en, sys_clk_en, wdt_osc_en;
   logic               brownout_detector_off, brownout_active, adc_clk_en, comp_clk_en;
   int                 err_count = 0, num_checks = 0;
   logic [7:0]         model_q;
   logic [7:0]         d;

   hppc_top i_dut (.*);

   // 125 MHz system clock
   always #4 core_clk = ~core_clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1;
      @(posedge core_clk);
      reg_wr    <= 0;
      if (a == PWR_CTL0_ADDR) model_q = v;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1;
      @(posedge core_clk);
      reg_rd   <= 0;
      #1 chk(reg_rdata, exp);
   endtask

   // Write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] v);
      @(posedge core_clk);
      reg_addr  <= PWR_CTL0_ADDR;
      reg_wdata <= v;
      reg_wr    <= 1;
      @(posedge core_clk);
      reg_wr    <= 0;
      reg_rd    <= 1;
      model_q   = v;
      @(posedge core_clk);
      reg_rd    <= 0;
      #1 chk(reg_rdata, model_q);
   endtask

   // Gate outputs settle two edges after the write
   task automatic gates();
      logic [3:0] g;
      @(posedge core_clk);
      #1;
      g = {model_q[4], ~model_q[4] & brownout_always_on_option, ~model_q[2], ~model_q[1]};
      chk({brownout_detector_off, brownout_active, adc_clk_en, comp_clk_en}, g);
   endtask

   // Halt, then wake by one source; por also restores the register
   task automatic halt_wake(input int src);
      @(posedge core_clk);
      halt_exec <= 1;
      @(posedge core_clk);
      halt_exec <= 0;
      repeat (2) @(posedge core_clk);
      #1 chk({cpu_halted, pc_hold, cpu_clk_en, sys_clk_en, wdt_osc_en}, 5'b11011);
      @(posedge core_clk);
      case (src)
         0: irq_pending <= 1;
         1: wdt_timeout <= 1;
         2: bor_reset <= 1;
         3: ext_reset_n_pin <= 0;
         default: por_pulse <= 1;
      endcase
      for (int i = 0; i < 10 && cpu_halted !== 1'b0; i++) @(posedge core_clk);
      {irq_pending, wdt_timeout, bor_reset, por_pulse} <= 4'h0;
      ext_reset_n_pin <= 1;
      if (src == 4) model_q = PWR_CTL0_RESET;
      repeat (6) @(posedge core_clk);
      #1 chk({cpu_halted, pc_hold, cpu_clk_en, sys_clk_en, wdt_osc_en}, 5'b00111);
   endtask

   // Cut a hung run short
   initial
   begin
      #200us;
      err_count++;
      results();
   end

   initial
   begin
      void'($urandom(32'h59E75D57));
      model_q = PWR_CTL0_RESET;
      // Two cycles; power-on reset loads the register meanwhile
      repeat (2) @(posedge core_clk);
      resetn    <= 1;
      por_pulse <= 0;
      repeat (6) @(posedge core_clk);
      rd(PWR_CTL0_ADDR, 8'h80);
      gates();
      for (int i = 0; i < 12; i++)
      begin
         @(posedge core_clk);
         brownout_always_on_option <= 1'($urandom);
         d = 8'h80 | (8'($urandom) & 8'h16);
         wr(PWR_CTL0_ADDR, d);
         gates();
         rd(PWR_CTL0_ADDR, model_q);
         wr(12'hF81 + 12'($urandom % 16), 8'($urandom));
         rd(12'hF7F, 8'h00);
         rd(PWR_CTL0_ADDR, model_q);
         wr_rd(8'h80 | (8'($urandom) & 8'h16));
         gates();
      end
      // Back-to-back strobes, then a system reset that spares the register
      wr_rd(8'h96);
      rd(PWR_CTL0_ADDR, 8'h96);
      @(posedge core_clk);
      resetn <= 0;
      repeat (4) @(posedge core_clk);
      resetn <= 1;
      rd(PWR_CTL0_ADDR, 8'h96);
      for (int s = 0; s < 5; s++)
         halt_wake(s);
      rd(PWR_CTL0_ADDR, 8'h80);
      gates();
      results();
   end
endmodule
